// ### verilog/sms_pkg.sv
// Purpose: shared constants for the serial peripheral port
// Assumes: one system clock, synchronous active-high reset
// Notes:   control field positions are fixed by this block
`default_nettype none
package sms_pkg;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 8;
  localparam int EDGE_W = 5;
  // sck edges per byte: eight pulses, two edges each
  localparam logic [EDGE_W-1:0] LAST_EDGE = 5'h0f;
  // control register field positions
  localparam int CTL_SEL_LO = 0;
  localparam int CTL_CPHA   = 2;
  localparam int CTL_CPOL   = 3;
  localparam int CTL_MASTER = 4;
  localparam int CTL_LSB    = 5;
  localparam int CTL_EN     = 6;
  localparam int CTL_IE     = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] RX_RESET  = 8'h00;
  localparam logic [7:0] TX_RESET  = 8'h00;
  // synchroniser reset: {nss_n, sck, mosi, miso}, select idles high
  localparam logic [3:0] PIN_RESET = 4'h8;
  localparam int PIN_NSS  = 3;
  localparam int PIN_SCK  = 2;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 0;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  typedef enum logic [1:0] {
    SMS_IDLE = 2'b01,
    SMS_RUN  = 2'b10
  } sms_state_e;
endpackage
`default_nettype wire

// ### verilog/sms_spi_port.sv
// Purpose: byte-wide full-duplex serial port, master or slave
// Assumes: pins pass a three-stage synchroniser; control is by strobes
// Notes:   sck rates count from clk_sys_i as the oscillator
`timescale 1ns/100ps
`default_nettype none
// Contract
// [RULE_01] only master data write starts transfer
// [RULE_02] master shifts eight bits, replaces with incoming
// [RULE_03] last bit copies shifter into receive buffer
// [RULE_04] master select comes from software GPIO
// [RULE_05] idle master write loads and starts immediately
// [RULE_06] busy write sets collision, byte dropped
// [RULE_07] clock select plus double speed pick rate
// [RULE_08] exactly eight sck pulses per master byte
// [RULE_09] master drives mosi, sck; samples miso
// [RULE_10] phase and polarity bits, both ends match
// [RULE_11] slave uses external sck, only while selected
// [RULE_12] enable gives pins serial function by mode
// [RULE_13] unselected slave write held until select
// [RULE_14] select release mid-byte aborts, no flag
// [RULE_15] every select assertion reloads pending byte
// [RULE_16] slave runs in suspend, interrupt wakes
// [RULE_17] each byte sets flag, requests interrupt
// [RULE_18] bit order selectable lsb or msb first
// [RULE_19] data reads return buffered receive byte
// [RULE_20] select low as master gives mode fault
// [RULE_21] byte over unread buffer flags overrun
// [RULE_22] flag clears on vector or status-data
// [RULE_23] collision and mode fault clear sequences
// [RULE_24] disabled port never shifts nor interrupts; irq_o ignores en, so a flag left set with ie still drives it
module sms_spi_port
  import sms_pkg::*;
(
  // clock and reset
  input  wire  logic        clk_sys_i,
  input  wire  logic        reset_i,
  // control register write and double speed
  input  wire  logic        ctl_wr_i,
  input  wire  logic [7:0]  ctl_wdata_i,
  input  wire  logic        double_speed_i,
  // register accesses
  input  wire  logic        data_wr_i,
  input  wire  logic [7:0]  data_wdata_i,
  input  wire  logic        data_rd_i,
  input  wire  logic        status_rd_i,
  input  wire  logic        vector_ack_i,
  // pins
  input  wire  logic        select_port_pin_n_i,
  input  wire  logic        clock_port_pin_i,
  output logic              clock_port_pin_o,
  output logic              clock_port_pin_oe_o,
  input  wire  logic        mosi_port_pin_i,
  output logic              mosi_port_pin_o,
  output logic              mosi_port_pin_oe_o,
  input  wire  logic        miso_port_pin_i,
  output logic              miso_port_pin_o,
  output logic              miso_port_pin_oe_o,
  // status
  output logic [7:0]        serial_control_o,
  output logic [7:0]        serial_data_o,
  output logic              transfer_done_flag_o,
  output logic              write_collision_o,
  output logic              mode_fault_o,
  output logic              rx_overrun_o,
  output logic              busy_o,
  output logic              irq_o
);

  logic [7:0]        serial_control_reg;
  logic              pins_reg;
  logic [3:0]        s1_reg;
  logic [3:0]        s2_reg;
  logic [3:0]        s3_reg;
  logic [3:0]        pin_reg;
  logic              sck_prev_reg;
  logic              nss_prev_reg;
  sms_state_e        state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic [EDGE_W-1:0] edge_reg;
  logic              sck_lvl_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        tx_hold_reg;
  logic              rx_bit_reg;
  logic [7:0]        serial_data_reg;
  logic              rx_full_reg;
  logic              flag_reg;
  logic              flag_arm_reg;
  logic              wcol_reg;
  logic              wcol_arm_reg;
  logic              modf_reg;
  logic              modf_arm_reg;
  logic              ovr_reg;
  logic              ovr_arm_reg;
  logic              dout_reg;

  // control fields
  wire       en      = serial_control_reg[CTL_EN];
  wire       master  = serial_control_reg[CTL_MASTER];
  wire       cpha    = serial_control_reg[CTL_CPHA];
  wire       cpol    = serial_control_reg[CTL_CPOL];
  wire       lsb     = serial_control_reg[CTL_LSB];
  wire       ie      = serial_control_reg[CTL_IE];
  wire [1:0] sel     = serial_control_reg[CTL_SEL_LO +: 2];

  // stable pin levels
  wire       nss_n   = pin_reg[PIN_NSS];
  wire       sck_in  = pin_reg[PIN_SCK];
  wire       mosi_in = pin_reg[PIN_MOSI];
  wire       miso_in = pin_reg[PIN_MISO];

  // half period of sck is 2^(2*sel+1-dbl) system clocks
  wire [2:0]       rate_sh  = {sel, 1'b1} - {2'b00, double_speed_i}; // RULE_07
  wire [CNT_W-1:0] half_len = CNT_W'(1) << rate_sh; // RULE_07
  wire             half_end = cnt_reg == half_len - CNT_W'(1);

  wire run_m   = state_reg == SMS_RUN;
  wire slv_act = en && !master && !nss_n; // RULE_11
  wire slv_bsy = slv_act && edge_reg != EDGE_W'(0);
  wire busy    = master ? run_m : slv_bsy;

  // sck edges, from own divider as master or the pin as slave
  wire m_edge  = run_m && half_end; // RULE_08
  wire s_edge  = slv_act && sck_in != sck_prev_reg; // RULE_11
  wire edge_ev = m_edge || s_edge;
  wire cur_lvl = master ? sck_lvl_reg : sck_prev_reg;
  wire lead    = edge_ev && cur_lvl == cpol; // RULE_10
  wire sample  = edge_ev && (lead ^ cpha); // RULE_10
  wire trail   = edge_ev && !lead;
  wire in_bit  = master ? miso_in : mosi_in; // RULE_09
  wire sh_in   = cpha ? in_bit : rx_bit_reg;
  wire [7:0] shifted = lsb ? {sh_in, shift_reg[7:1]}
                           : {shift_reg[6:0], sh_in}; // RULE_18
  wire byte_done = trail && edge_reg == LAST_EDGE; // RULE_02

  // software data write
  wire wr_coll = data_wr_i && en && busy; // RULE_06
  wire wr_ok   = data_wr_i && !wr_coll;
  wire m_start = wr_ok && en && master; // RULE_01
  wire s_load  = wr_ok && slv_act; // RULE_13
  wire s_sel   = slv_act && nss_prev_reg; // RULE_15
  wire s_abort = !master && !nss_prev_reg && nss_n
                 && edge_reg != EDGE_W'(0); // RULE_14
  wire modf_ev = en && master && !nss_n; // RULE_20

  wire [7:0] sh_next = m_start ? data_wdata_i :
                       s_load  ? data_wdata_i :
                       s_sel   ? tx_hold_reg :
                       trail   ? shifted : shift_reg;
  // phase one launches each bit on the leading edge, clear of sampling
  wire out_now   = lsb ? shift_reg[0] : shift_reg[7];
  wire reload    = m_start || s_load || s_sel;
  wire dout_phs0 = lsb ? sh_next[0] : sh_next[7];
  wire dout_phs1 = reload ? dout_phs0 : lead ? out_now : dout_reg; // RULE_10
  wire dout_next = cpha ? dout_phs1 : dout_phs0;

  wire data_acc  = data_rd_i || data_wr_i;
  wire set_flag  = byte_done || modf_ev; // RULE_17
  wire flag_next = set_flag ||
                   (flag_reg && !vector_ack_i &&
                    !(flag_arm_reg && data_acc)); // RULE_22
  wire ovr_ev    = byte_done && rx_full_reg; // RULE_21

  // pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      s1_reg  <= PIN_RESET;
      s2_reg  <= PIN_RESET;
      s3_reg  <= PIN_RESET;
      pin_reg <= PIN_RESET;
    end
    else
    begin
      s1_reg  <= {select_port_pin_n_i, clock_port_pin_i,
                  mosi_port_pin_i, miso_port_pin_i};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));
    end
  end

  // control register; mode fault drops master and pin ownership
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      serial_control_reg <= CTL_RESET;
      pins_reg           <= 1'b0;
    end
    else if (modf_ev)
    begin
      serial_control_reg[CTL_MASTER] <= 1'b0; // RULE_20
      pins_reg                       <= 1'b0; // RULE_20
    end
    else if (ctl_wr_i)
    begin
      serial_control_reg <= ctl_wdata_i;
      pins_reg           <= 1'b1; // RULE_12
    end
  end

  // shifter, divider and edge counter
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state_reg    <= SMS_IDLE;
      cnt_reg      <= CNT_RESET;
      edge_reg     <= '0;
      sck_lvl_reg  <= 1'b0;
      sck_prev_reg <= 1'b0;
      nss_prev_reg <= 1'b1;
      shift_reg    <= TX_RESET;
      tx_hold_reg  <= TX_RESET;
      rx_bit_reg   <= 1'b0;
      dout_reg     <= 1'b0;
    end
    else
    begin
      sck_prev_reg <= sck_in;
      nss_prev_reg <= nss_n;
      shift_reg    <= sh_next; // RULE_02
      dout_reg     <= dout_next;
      if (wr_ok)
        tx_hold_reg <= data_wdata_i; // RULE_13
      if (sample)
        rx_bit_reg <= in_bit;
      case (state_reg)
        SMS_IDLE:
        begin
          sck_lvl_reg <= cpol;
          cnt_reg     <= CNT_RESET;
          if (m_start)
            state_reg <= SMS_RUN; // RULE_05
        end
        SMS_RUN:
        begin
          cnt_reg <= half_end ? CNT_RESET : cnt_reg + CNT_W'(1);
          if (half_end)
            sck_lvl_reg <= !sck_lvl_reg; // RULE_08
          if (byte_done || !en || modf_ev)
            state_reg <= SMS_IDLE; // RULE_24
        end
        default:
          state_reg <= SMS_IDLE;
      endcase
      if (m_start || s_sel || s_abort || byte_done || !en)
        edge_reg <= '0; // RULE_14
      else if (edge_ev)
        edge_reg <= edge_reg + EDGE_W'(1);
    end
  end

  // receive buffer and flags; a set always wins over a clear
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      serial_data_reg <= RX_RESET;
      rx_full_reg     <= 1'b0;
      flag_reg        <= 1'b0;
      flag_arm_reg    <= 1'b0;
      wcol_reg        <= 1'b0;
      wcol_arm_reg    <= 1'b0;
      modf_reg        <= 1'b0;
      modf_arm_reg    <= 1'b0;
      ovr_reg         <= 1'b0;
      ovr_arm_reg     <= 1'b0;
    end
    else
    begin
      if (byte_done)
        serial_data_reg <= shifted; // RULE_03
      rx_full_reg <= byte_done || (rx_full_reg && !data_rd_i); // RULE_19
      flag_reg    <= flag_next; // RULE_17
      flag_arm_reg <= (status_rd_i && flag_reg) ||
                      (flag_arm_reg && !data_acc); // RULE_22
      wcol_reg <= wr_coll ||
                  (wcol_reg && !(wcol_arm_reg && data_acc)); // RULE_23
      wcol_arm_reg <= (status_rd_i && wcol_reg) ||
                      (wcol_arm_reg && !data_acc);
      modf_reg <= modf_ev ||
                  (modf_reg && !(modf_arm_reg && ctl_wr_i)); // RULE_23
      modf_arm_reg <= (status_rd_i && modf_reg) ||
                      (modf_arm_reg && !ctl_wr_i);
      ovr_reg <= ovr_ev ||
                 (ovr_reg && !(ovr_arm_reg && data_acc)); // RULE_21
      ovr_arm_reg <= (status_rd_i && ovr_reg) ||
                     (ovr_arm_reg && !data_acc);
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      clock_port_pin_o     <= 1'b0;
      clock_port_pin_oe_o  <= 1'b0;
      mosi_port_pin_o      <= 1'b0;
      mosi_port_pin_oe_o   <= 1'b0;
      miso_port_pin_o      <= 1'b0;
      miso_port_pin_oe_o   <= 1'b0;
      serial_control_o     <= CTL_RESET;
      serial_data_o        <= RX_RESET;
      transfer_done_flag_o <= 1'b0;
      write_collision_o    <= 1'b0;
      mode_fault_o         <= 1'b0;
      rx_overrun_o         <= 1'b0;
      busy_o               <= 1'b0;
      irq_o                <= 1'b0;
    end
    else
    begin
      clock_port_pin_o     <= sck_lvl_reg; // RULE_09
      clock_port_pin_oe_o  <= en && master && pins_reg; // RULE_12
      mosi_port_pin_o      <= dout_reg; // RULE_09
      mosi_port_pin_oe_o   <= en && master && pins_reg; // RULE_12
      miso_port_pin_o      <= dout_reg; // RULE_11
      miso_port_pin_oe_o   <= slv_act && pins_reg; // RULE_12
      serial_control_o     <= serial_control_reg;
      serial_data_o        <= serial_data_reg; // RULE_19
      transfer_done_flag_o <= flag_reg;
      write_collision_o    <= wcol_reg;
      mode_fault_o         <= modf_reg;
      rx_overrun_o         <= ovr_reg;
      busy_o               <= busy;
      irq_o                <= flag_reg && ie; // RULE_16
    end
  end

endmodule
`default_nettype wire

// ### sim/sms_spi_port_props.sv
// Purpose: concurrent checks on the serial port pins and flags
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to every instance of the port by bind
`timescale 1ns/100ps
`default_nettype none
module sms_spi_port_props
  import sms_pkg::*;
(
  // clock, reset and strobes
  input wire logic       clk_sys_i,
  input wire logic       reset_i,
  input wire logic       data_wr_i,
  input wire logic       vector_ack_i,
  // pins and status
  input wire logic       clock_port_pin_o,
  input wire logic       clock_port_pin_oe_o,
  input wire logic       mosi_port_pin_oe_o,
  input wire logic       miso_port_pin_oe_o,
  input wire logic [7:0] serial_control_o,
  input wire logic       transfer_done_flag_o,
  input wire logic       write_collision_o,
  input wire logic       busy_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic [4:0] tog_reg;
  wire        mst = serial_control_o[CTL_EN] && serial_control_o[CTL_MASTER];
  // sck output toggles since the byte started
  always_ff @(posedge clk_sys_i)
    if (reset_i || $rose(busy_o))
      tog_reg <= 5'h00;
    else if (clock_port_pin_o != $past(clock_port_pin_o))
      tog_reg <= tog_reg + 5'h01;
  chk_off_no_clock: assert property (!mst |-> !clock_port_pin_oe_o)
    else $error("sck driven while not an enabled master");
  chk_master_pins: assert property (
    mst |-> mosi_port_pin_oe_o && clock_port_pin_oe_o)
    else $error("master does not drive mosi and sck");
  chk_slave_miso: assert property (
    miso_port_pin_oe_o |->
      serial_control_o[CTL_EN] && !serial_control_o[CTL_MASTER])
    else $error("miso driven outside slave mode");
  chk_start_busy: assert property (
    data_wr_i && !busy_o && mst |-> ##2 busy_o)
    else $error("idle master write did not start");
  chk_wcol_cause: assert property (
    $rose(write_collision_o) |-> $past(data_wr_i) || $past(data_wr_i, 2))
    else $error("collision without a data write");
  // the last toggle lands in the counter one edge after the flag rises
  chk_eight_pulses: assert property (
    $rose(transfer_done_flag_o) && tog_reg != 5'h00
    |-> ##1 tog_reg == 5'h10)
    else $error("master byte without eight sck pulses");
  chk_vec_clear: assert property (
    vector_ack_i && !busy_o |-> ##[1:2] !transfer_done_flag_o)
    else $error("vector taken but flag stays set");
  chk_irq_from_flag: assert property (
    irq_o == (transfer_done_flag_o && serial_control_o[CTL_IE]))
    else $error("interrupt does not follow flag and enable");
endmodule
bind sms_spi_port sms_spi_port_props u_props (.*);
`default_nettype wire

// ### sim/sms_slave_model.sv
// Purpose: behavioural serial peripheral on the far side of a master
// Assumes: select comes from a bench general-purpose line
// Notes:   a released miso shows the inverse bit, never a stale one
`timescale 1ns/100ps
`default_nettype none
module sms_slave_model (
  // pins
  input  wire logic       nss_n_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  // setup and data
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  input  wire logic [7:0] tx_i,
  output logic [7:0]      rx_o
);
  logic [2:0] n = 3'h0;
  logic [2:0] m = 3'h0;
  wire        smp = sck_i ^ cpol_i ^ cpha_i;
  wire        cur = tx_i[lsb_i ? m : 3'h7 - m];
  assign miso_o = nss_n_i ? ~cur : cur;
  always @(negedge nss_n_i)
  begin
    n = 3'h0;
    m = 3'h0;
  end
  always @(posedge smp)
    if (!nss_n_i)
    begin
      rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
      n = n + 3'h1;
    end
  always @(negedge smp)
    if (!nss_n_i)
      m = n;
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Purpose: self-checking bench for the serial port
// Assumes: slave model on the far side while the port is master
// Notes:   bench plays the external master in slave mode
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sms_pkg::*;
  logic       clk_sys = 1'b0, rst = 1'b1, dbl = 1'b0, tsck = 1'b0;
  logic       cw = 1'b0, dw = 1'b0, dr = 1'b0, sr = 1'b0, va = 1'b0;
  logic [7:0] cd = 8'h00, wd = 8'h00, mtx = 8'h00, got;
  logic       nss_n = 1'b1, msel_n = 1'b1, tmosi = 1'b0, mi_m, irq;
  logic       sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, fl, wc, mf, ov, bz;
  logic [7:0] ctl, rxd, mrx;
  int         err_total = 0, check_count = 0;
  wire        sck = sck_oe ? sck_o : tsck;
  wire        mosi = mo_oe ? mo_o : tmosi;
  wire        miso = mi_oe ? mi_o : mi_m;
  always #2 clk_sys = ~clk_sys;
  sms_spi_port u_dut (
    .clk_sys_i(clk_sys), .reset_i(rst), .ctl_wr_i(cw), .ctl_wdata_i(cd),
    .double_speed_i(dbl), .data_wr_i(dw), .data_wdata_i(wd),
    .data_rd_i(dr), .status_rd_i(sr), .vector_ack_i(va),
    .select_port_pin_n_i(nss_n), .clock_port_pin_i(sck),
    .clock_port_pin_o(sck_o), .clock_port_pin_oe_o(sck_oe),
    .mosi_port_pin_i(mosi), .mosi_port_pin_o(mo_o),
    .mosi_port_pin_oe_o(mo_oe), .miso_port_pin_i(miso),
    .miso_port_pin_o(mi_o), .miso_port_pin_oe_o(mi_oe),
    .serial_control_o(ctl), .serial_data_o(rxd),
    .transfer_done_flag_o(fl), .write_collision_o(wc),
    .mode_fault_o(mf), .rx_overrun_o(ov), .busy_o(bz), .irq_o(irq));
  sms_slave_model u_peer (
    .nss_n_i(msel_n), .sck_i(sck), .mosi_i(mosi), .miso_o(mi_m),
    .cpol_i(cd[CTL_CPOL]), .cpha_i(cd[CTL_CPHA]), .lsb_i(cd[CTL_LSB]),
    .tx_i(mtx), .rx_o(mrx));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] v);
    check_count++;
    if (v !== ex)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, ex, v);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys) s = 1'b1;
    @(negedge clk_sys) s = 1'b0;
  endtask
  task automatic wr_ctl(input logic [7:0] c);
    cd = c;
    pulse(cw);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic mx(input logic [7:0] c, input logic d, input logic [7:0] tx,
                    input logic [7:0] srx, input logic [1:0] k);
    int n;
    int h;
    h = 1 << (2 * c[1:0] + 1 - d);
    wr_ctl(c);
    dbl = d;
    mtx = srx;
    msel_n = 1'b0;
    wd = tx;
    pulse(dw);
    for (n = 0; n < 600 && sck_o === c[CTL_CPOL]; n++) @(negedge clk_sys);
    for (n = 0; n < 600 && sck_o !== c[CTL_CPOL]; n++) @(negedge clk_sys);
    chk("half period", 8'(h), 8'(n));
    wd = 8'h0f;
    if (k[0]) pulse(dw);
    for (n = 0; n < 5000 && fl !== 1'b1; n++) @(negedge clk_sys);
    msel_n = 1'b1;
    chk("done flag", 8'h01, 8'(fl));
    if (fl !== 1'b1) tally_and_finish();
    chk("irq", 8'h01, 8'(irq));
    chk("peer got", tx, mrx);
    if (h > 4) chk("rx byte", srx, rxd);
    if (k[1]) pulse(va);
    else
    begin
      pulse(sr);
      pulse(dr);
    end
    repeat (3) @(negedge clk_sys);
    chk("flag clear", 8'h00, 8'(fl));
  endtask
  task automatic sb(input logic [7:0] b, input int nb);
    nss_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    got = 8'h00;
    for (int i = 0; i < nb; i++)
    begin
      tmosi = b[7 - i];
      repeat (20) @(negedge clk_sys);
      got = {got[6:0], miso};
      tsck = 1'b1;
      repeat (20) @(negedge clk_sys);
      tsck = 1'b0;
    end
    repeat (20) @(negedge clk_sys);
    nss_n = 1'b1;
    repeat (10) @(negedge clk_sys);
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("reset control", 8'h00, ctl);
    for (int i = 0; i < 8; i++)
      mx({3'b110 | 3'(i[0]), 1'b1, i[1], i[0] ^ i[2], i[2:1]}, i[0],
         8'h5a ^ 8'(i), 8'h3c + 8'(i), 2'b00);
    $display("test master rates done");
    mx(8'hd1, 1'b0, 8'ha5, 8'h81, 2'b11);
    chk("collision", 8'h01, 8'(wc));
    mx(8'hd1, 1'b0, 8'h66, 8'h99, 2'b10);
    chk("overrun", 8'h01, 8'(ov));
    pulse(sr);
    pulse(dr);
    repeat (3) @(negedge clk_sys);
    chk("errors cleared", 8'h00, 8'({wc, ov}));
    $display("test errors done");
    wr_ctl(8'hd1);
    nss_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    chk("mode fault", 8'h0c, 8'({mf, fl, ctl[CTL_MASTER], sck_oe}));
    nss_n = 1'b1;
    pulse(va);
    pulse(sr);
    wr_ctl(8'h40);
    chk("fault clear", 8'h00, 8'({mf, fl}));
    $display("test mode fault done");
    wd = 8'h3c;
    pulse(dw);
    repeat (8) @(negedge clk_sys);
    chk("held", 8'h00, 8'(bz));
    sb(8'h96, 8);
    chk("slave out", 8'h3c, got);
    chk("slave in", 8'h96, rxd);
    chk("slave flag", 8'h01, 8'(fl));
    pulse(va);
    sb(8'hff, 3);
    chk("abort", 8'h00, 8'(fl));
    $display("test slave done");
    wr_ctl(8'h10);
    wd = 8'h77;
    pulse(dw);
    repeat (20) @(negedge clk_sys);
    chk("disabled", 8'h00, 8'({bz, sck_oe, fl}));
    $display("test disabled done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
